/* File: pdt_pkg.sv */
/*
 package for the prescaled down timer: register offsets, field layout,
 reset values. assumes a 32-bit apb slave with one word per register.
*/
// Operation
// - the count is a 16-bit register that software reads and writes.
// - the count steps down once per prescaler pass below zero, no more.
// - a count underflow or reset reloads the period; only the underflow raises the irq.
// - a 16-bit period register sets the period and the reload value.
// - a 4-bit divide-down field sets the prescale ratio, reset 0000.
// - 4-bit prescale count reloads divide-down on underflow or reset.
// - reload bit 1 loads count from period, prescale from divide-down.
// - counting halts while the stop bit is set; stop resets to 0.
// - each count underflow sets the timer irq flag in the flag register.
package pdt_pkg;
    localparam int unsigned pdt_aw = 4;
    localparam logic [pdt_aw-1:0] pdt_off_control = 4'h0;
    localparam logic [pdt_aw-1:0] pdt_off_count = 4'h4;
    localparam logic [pdt_aw-1:0] pdt_off_period = 4'h8;
    localparam logic [pdt_aw-1:0] pdt_off_flags = 4'hc;
    localparam int unsigned pdt_cw = 16;
    localparam int unsigned pdt_pw = 4;
    localparam int unsigned pdt_lane_w = 8;
    localparam int unsigned pdt_lanes = pdt_cw / pdt_lane_w;
    // control and flag register layout, reset values
    localparam int unsigned pdt_ddf_lsb = 0;
    localparam int unsigned pdt_stop_pos = 4;
    localparam int unsigned pdt_reload_pos = 5;
    localparam int unsigned pdt_psc_lsb = 6;
    localparam int unsigned pdt_flag_pos = 0;
    localparam logic [pdt_pw-1:0] pdt_ddf_rst = 4'h0;
    localparam logic [pdt_cw-1:0] pdt_period_rst = 16'hffff;
    localparam logic [pdt_cw-1:0] pdt_count_rst = 16'hffff;
endpackage : pdt_pkg

/* File: pdt_down_counter.sv */
/*
 down counter with reload: steps on an enable, flags underflow.
 assumes load and step come from the same clock domain.
*/
module pdt_down_counter #(
    parameter int unsigned width = 4,
    parameter logic [width-1:0] reset_value = '1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [width-1:0] load_value,
    input wire logic step,
    output logic [width-1:0] count,
    output logic underflow
);
    logic [width-1:0] count_q;
    logic [width-1:0] count_d;
    wire logic at_zero = (count_q == '0);
    assign underflow = step && at_zero && !load;
    assign count_d = load ? load_value :
                     underflow ? load_value : count_q - 1'b1;
    assign count = count_q;
    // reset value is a parameter so the async branch stays constant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= reset_value;
        end else if (load || step) begin
            count_q <= count_d;
        end
    end
endmodule : pdt_down_counter

/* File: pdt_timer.sv */
/*
 prescaled down timer with apb register access.
 assumes a single pclk domain; the irq flag is cleared by writing 1.
*/
module pdt_timer
    import pdt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pdt_pkg::pdt_aw-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic timer_irq_pulse,
    output logic timer_irq_flag
);
    logic [pdt_pw-1:0] ddf_q;
    logic stop_q;
    logic [pdt_cw-1:0] period_q;
    logic flag_q;
    logic [31:0] prdata_q;
    logic [pdt_pw-1:0] prescale_count;
    logic [pdt_cw-1:0] cnt;
    logic psc_uf;
    logic cnt_uf;

    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic sel_ctl = (paddr == pdt_off_control);
    wire logic sel_cnt = (paddr == pdt_off_count);
    wire logic sel_prd = (paddr == pdt_off_period);
    wire logic sel_flg = (paddr == pdt_off_flags);
    wire logic mapped = sel_ctl || sel_cnt || sel_prd || sel_flg;
    wire logic [pdt_lanes-1:0] lane_en = pstrb[pdt_lanes-1:0];
    wire logic lo_en = lane_en[0];
    wire logic wr_ctl = wr && sel_ctl && lo_en;
    // reload bit is self-clearing: acts on the write, reads back 0
    wire logic reload = wr_ctl && pwdata[pdt_reload_pos];
    // a reload in the same write takes the divide-down being written
    wire logic [pdt_pw-1:0] ddf_next = wr_ctl ?
        pwdata[pdt_ddf_lsb +: pdt_pw] : ddf_q;
    wire logic wr_cnt = wr && sel_cnt && (|lane_en);
    wire logic wr_prd = wr && sel_prd;
    wire logic run = !stop_q;
    logic [pdt_cw-1:0] cnt_wval;

    // per byte lane: a partial write keeps the other lane
    for (genvar i = 0; i < pdt_lanes; i++) begin : g_lane
        localparam int unsigned lsb = i * pdt_lane_w;
        logic [pdt_lane_w-1:0] prd_lane_q;
        assign cnt_wval[lsb +: pdt_lane_w] = lane_en[i] ?
            pwdata[lsb +: pdt_lane_w] : cnt[lsb +: pdt_lane_w];
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                prd_lane_q <= pdt_period_rst[lsb +: pdt_lane_w];
            end else if (wr_prd && lane_en[i]) begin
                prd_lane_q <= pwdata[lsb +: pdt_lane_w];
            end
        end
        assign period_q[lsb +: pdt_lane_w] = prd_lane_q;
    end

    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata = prdata_q;
    assign timer_irq_flag = flag_q;
    assign timer_irq_pulse = cnt_uf;

    // prescaler, steps each clock while running
    pdt_down_counter #(
        .width(pdt_pw),
        .reset_value(pdt_ddf_rst)
    ) u_psc (
        .pclk(pclk),
        .presetn(presetn),
        .load(reload),
        .load_value(ddf_next),
        .step(run),
        .count(prescale_count),
        .underflow(psc_uf)
    );

    // main counter; software write of the count wins over a step
    // reset count equals the period reset: a reset reloads the period
    pdt_down_counter #(
        .width(pdt_cw),
        .reset_value(pdt_period_rst)
    ) u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .load(reload || wr_cnt),
        .load_value(wr_cnt ? cnt_wval : period_q),
        .step(psc_uf),
        .count(cnt),
        .underflow(cnt_uf)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ddf_q <= pdt_ddf_rst;
            stop_q <= 1'b0;
        end else if (wr_ctl) begin
            ddf_q <= pwdata[pdt_ddf_lsb +: pdt_pw];
            stop_q <= pwdata[pdt_stop_pos];
        end
    end

    // set beats write-one-to-clear
    wire logic flag_clr = wr && sel_flg && lo_en && pwdata[pdt_flag_pos];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (cnt_uf) begin
            flag_q <= 1'b1;
        end else if (flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    wire logic [31:0] ctl_view = {16'h0000, 6'h00, prescale_count, 1'b0, stop_q, ddf_q};
    wire logic [31:0] rd_mux = sel_ctl ? ctl_view :
                               sel_cnt ? {16'h0000, cnt} :
                               sel_prd ? {16'h0000, period_q} :
                               sel_flg ? {31'h0, flag_q} : 32'h0;
    // registered read data, captured during setup so it is valid in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end
endmodule : pdt_timer

/* File: pdt_timer_props.sv */
/* checker: apb replies and irq flag at the timer ports.
 assumes the pdt_timer port list and the pdt_pkg offsets. */
module pdt_timer_props
    import pdt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pdt_pkg::pdt_aw-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic timer_irq_pulse,
    input wire logic timer_irq_flag
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable;
    wire logic rdc = acc && !pwrite;
    wire logic clr = acc && pwrite && paddr == pdt_off_flags && pwdata[0];
    wire logic wctl = acc && pwrite && paddr == pdt_off_control;
    logic stop_q;
    // stop tracked from writes, no view inside
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) stop_q <= 1'b0;
        else if (wctl) stop_q <= pwdata[pdt_stop_pos];
    sequence s_clear;
        clr && !timer_irq_pulse;
    endsequence
    chk_flag_set: assert property (
        timer_irq_pulse |=> timer_irq_flag)
        else $error("flag not set after pulse");
    chk_flag_sticky: assert property (
        timer_irq_flag && !clr |=> timer_irq_flag)
        else $error("flag dropped");
    chk_flag_clear: assert property (
        s_clear |=> !timer_irq_flag)
        else $error("flag not cleared");
    chk_flag_cause: assert property (
        $rose(timer_irq_flag) |-> $past(timer_irq_pulse))
        else $error("flag without pulse");
    chk_stop_quiet: assert property (
        stop_q && $past(stop_q) |-> !timer_irq_pulse)
        else $error("pulse while stopped");
    chk_unmapped_err: assert property (
        acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("no error on unmapped");
    chk_upper_zero: assert property (
        rdc |-> prdata[31:16] == 16'h0)
        else $error("upper read bits set");
    chk_reload_zero: assert property (
        rdc && paddr == pdt_off_control
        |-> prdata[15:10] == 6'h0 && !prdata[pdt_reload_pos])
        else $error("reload bit reads set");
endmodule : pdt_timer_props
bind pdt_timer pdt_timer_props chk (.*);

/* File: tb_pdt_timer.sv */
/* bench for pdt_timer: apb calls with expected values.
 assumes zero wait states are not relied on. */
module tb_pdt_timer;
    timeunit 1ns;
    timeprecision 1ps;
    import pdt_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic [3:0] paddr = 4'h0;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic pready, pslverr, timer_irq_pulse, timer_irq_flag;
    int failures = 0, check_count = 0, n;
    // reset count is the period reset value, less three clock steps
    logic [31:0] exp_cnt = {16'h0000, pdt_period_rst - 16'h0003};
    pdt_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_irq_pulse(timer_irq_pulse), .timer_irq_flag(timer_irq_flag));
    task automatic give_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] seen, exp, input string what);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s exp %h got %h", what, exp, seen);
        end
    endtask : chk
    task automatic bail(input int lim);
        if (n >= lim) begin
            failures++;
            give_verdict();
        end
    endtask : bail
    task automatic apb(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        bail(50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // counts edges up to the next underflow pulse
    task automatic wait_pulse;
        for (n = 1; n < 100; n++) begin
            @(posedge pclk);
            if (timer_irq_pulse === 1'b1) break;
        end
        bail(100);
    endtask : wait_pulse
    initial begin
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, pdt_off_control, 32'h0);
        chk(rd, 32'h0, "ctrl reset");
        apb(1'b0, pdt_off_count, 32'h0);
        chk(rd, exp_cnt, "count run");
        apb(1'b1, pdt_off_control, 32'h10);
        apb(1'b1, pdt_off_period, 32'h3);
        apb(1'b1, pdt_off_count, 32'h2);
        repeat (20) @(posedge pclk);
        apb(1'b0, pdt_off_count, 32'h0);
        chk(rd, 32'h2, "count held");
        apb(1'b1, pdt_off_control, 32'h32);
        apb(1'b0, pdt_off_count, 32'h0);
        chk(rd, 32'h3, "count reload");
        apb(1'b0, pdt_off_control, 32'h0);
        chk(rd, 32'h92, "ctrl reload");
        apb(1'b1, pdt_off_control, 32'h2);
        wait_pulse();
        wait_pulse();
        chk(n, 32'hc, "period clocks");
        chk(timer_irq_flag, 1'b1, "flag set");
        // stop first so no new underflow races the clear
        apb(1'b1, pdt_off_control, 32'h12);
        apb(1'b0, pdt_off_flags, 32'h0);
        chk(rd, 32'h1, "flag read");
        apb(1'b1, pdt_off_flags, 32'h1);
        apb(1'b0, pdt_off_flags, 32'h0);
        chk(rd, 32'h0, "flag clear");
        apb(1'b1, 4'h2, 32'hffff);
        apb(1'b0, 4'h2, 32'h0);
        chk({rd[30:0], er}, 32'h1, "unmapped");
        apb(1'b0, pdt_off_period, 32'h0);
        chk(rd, 32'h3, "period kept");
        // second reset while the timer is stopped: fields return to their reset values
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, pdt_off_control, 32'h0);
        chk(rd, 32'h0, "ctrl rst again");
        apb(1'b0, pdt_off_period, 32'h0);
        chk(rd, {16'h0000, pdt_period_rst}, "period rst");
        give_verdict();
    end
endmodule : tb_pdt_timer
